// ===== verilog/pin_mux_map.svh
`ifndef PIN_MUX_MAP_SVH
`define PIN_MUX_MAP_SVH
`define PORTC_PUR_PHASE_A1_BIT 0
`define PORTC_PUR_PHASE_B1_BIT 1
`define PORTC_PUR_DECODER0_INDEX_PIN_BIT   6
`define PORTC_PUR_DECODER0_HOME_PIN_BIT    7
`define PORTE_PUR_SPI_PORT0_CLOCK_PIN_BIT    4
`define PORTE_PUR_TIMERC0_BIT  8
`define PORTE_PUR_TIMERC1_BIT  9
`define PAD_DECODER0_INDEX_PIN             0
`define PAD_DECODER0_HOME_PIN              1
`define PAD_SPI0_CLOCK         2
`define PAD_PHASE_A1           3
`define PAD_PHASE_B1           4
`define PAD_CAN_RX             5
`define PAD_CAN_TX             6
`define PAD_TIMERC0            7
`define PAD_TIMERC1            8
`define PAD_COUNT              9
`endif

// ===== verilog/pin_mux_pkg.sv
package pin_mux_pkg;
  // Per-pad control carried from mux to pad ring
  typedef struct packed {
    logic outEnable;
    logic outValue;
    logic pullupOn;
  } pad_ctrl_type;
  // Per-pin GPIO configuration
  typedef struct packed {
    logic gpioSelect;
    logic gpioDirOut;
    logic gpioData;
    logic openDrain;
  } gpio_cfg_type;
endpackage

// ===== verilog/multiplexed_pin_function_select.sv
// Function
// - After reset the index pad feeds decoder 0 index with pull-up on.
// - Port C pull-up bit 6 low removes the index pad pull-up.
// - After reset the home pad feeds decoder 0 home; port C bit 7 low drops its pull-up.
// - The SPI0 clock pad is an output as master and a clock input as slave.
// - The SPI0 clock pad defaults to SPI; port E bit 4 low drops its pull-up.
// - Phase A alternate select routes the phase A1 pad to SPI1 clock.
// - Phase B alternate select routes the phase B1 pad to SPI1 data out as master and to SPI1 data in as slave.
// - The master shows each data bit half a clock before the latching edge.
// - After reset phase A1 and B1 pads feed the decoder 1 phase inputs.
// - Port C bits 0 and 1 low drop pull-ups on phase A1 and B1 pads.
// - CAN receive pad has pull-up by default; the CAN disable bit removes it.
// - Open-drain pads drop pull-up while low and keep it when high if enabled.
// - Push-pull driving pads keep pull-up off at either level.
// - Timer C channel pads default to timer function, not GPIO.
// - Each GPIO-capable pad sets its own direction when in GPIO mode.
// - During reset the shared pads are inputs with pull-ups on.
`timescale 1ns/100ps
`include "pin_mux_map.svh"
module multiplexed_pin_function_select #(
  parameter int NPADS = `PAD_COUNT
) (
  input  wire logic                             clk,
  input  wire logic                             rst_b,
  input  wire logic [15:0]                      portCPullupEnable,
  input  wire logic [15:0]                      portEPullupEnable,
  input  wire logic                             canPullupDisable,
  input  wire logic                             phaseAAlternateSelect,
  input  wire logic                             phaseBAlternateSelect,
  input  wire pin_mux_pkg::gpio_cfg_type [NPADS-1:0] gpioCfg,
  input  wire logic                             spi0Master,
  input  wire logic                             spi0ClockOut,
  input  wire logic                             spi1Master,
  input  wire logic                             spi1ClockOut,
  input  wire logic                             spi1DataOut,
  input  wire logic                             canTxData,
  input  wire logic                             timerC0Out,
  input  wire logic                             timerC0OutEnable,
  input  wire logic                             timerC1Out,
  input  wire logic                             timerC1OutEnable,
  input  wire logic [NPADS-1:0]                 padIn,
  output pin_mux_pkg::pad_ctrl_type [NPADS-1:0] padCtrl,
  output logic [NPADS-1:0]                      gpioIn,
  output logic                                  decoder0Index,
  output logic                                  decoder0Home,
  output logic                                  decoder1PhaseA,
  output logic                                  decoder1PhaseB,
  output logic                                  spi0ClockIn,
  output logic                                  spi1ClockIn,
  output logic                                  spi1DataIn,
  output logic                                  canRxData,
  output logic                                  timerC0In,
  output logic                                  timerC1In
);

  logic              rstMeta;
  logic              rstSync;
  logic [NPADS-1:0]  padMeta;
  logic [NPADS-1:0]  padSync;
  logic [NPADS-1:0]  pullEnable;
  logic [NPADS-1:0]  periphOe;
  logic [NPADS-1:0]  periphOut;
  logic [NPADS-1:0]  periphOd;
  pin_mux_pkg::pad_ctrl_type [NPADS-1:0] next_padCtrl;

  // Reset released through two flops
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // Pad inputs are asynchronous to clk
  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      padMeta <= '0;
      padSync <= '0;
    end
    else
    begin
      padMeta <= padIn;
      padSync <= padMeta;
    end
  end

  // Software pull-up enables per pad
  always_comb
  begin
    pullEnable = '1;
    pullEnable[`PAD_DECODER0_INDEX_PIN]   = portCPullupEnable[`PORTC_PUR_DECODER0_INDEX_PIN_BIT];
    pullEnable[`PAD_DECODER0_HOME_PIN]    = portCPullupEnable[`PORTC_PUR_DECODER0_HOME_PIN_BIT];
    pullEnable[`PAD_SPI0_CLOCK] = portEPullupEnable[`PORTE_PUR_SPI_PORT0_CLOCK_PIN_BIT];
    pullEnable[`PAD_PHASE_A1] = portCPullupEnable[`PORTC_PUR_PHASE_A1_BIT];
    pullEnable[`PAD_PHASE_B1] = portCPullupEnable[`PORTC_PUR_PHASE_B1_BIT];
    pullEnable[`PAD_CAN_RX]   = !canPullupDisable;
    pullEnable[`PAD_CAN_TX]   = !canPullupDisable;
    pullEnable[`PAD_TIMERC0]  = portEPullupEnable[`PORTE_PUR_TIMERC0_BIT];
    pullEnable[`PAD_TIMERC1]  = portEPullupEnable[`PORTE_PUR_TIMERC1_BIT];
  end

  // Peripheral drive when the pad is not in GPIO mode
  always_comb
  begin
    periphOe  = '0;
    periphOut = '0;
    periphOd  = '0;
    periphOe[`PAD_SPI0_CLOCK]  = spi0Master;
    periphOut[`PAD_SPI0_CLOCK] = spi0ClockOut;
    periphOe[`PAD_PHASE_A1]  = phaseAAlternateSelect & spi1Master;
    periphOut[`PAD_PHASE_A1] = spi1ClockOut;
    // SPI1 master changes data out half a clock ahead of the latch edge
    periphOe[`PAD_PHASE_B1]  = phaseBAlternateSelect & spi1Master;
    periphOut[`PAD_PHASE_B1] = spi1DataOut;
    periphOe[`PAD_CAN_TX]  = 1'b1;
    periphOut[`PAD_CAN_TX] = canTxData;
    periphOd[`PAD_CAN_TX]  = 1'b1;
    periphOe[`PAD_TIMERC0]  = timerC0OutEnable;
    periphOut[`PAD_TIMERC0] = timerC0Out;
    periphOe[`PAD_TIMERC1]  = timerC1OutEnable;
    periphOut[`PAD_TIMERC1] = timerC1Out;
  end

  // Final pad control: GPIO overrides, then drive-mode pull-up policy
  always_comb
  begin
    logic oe;
    logic val;
    logic od;
    oe  = 1'b0;
    val = 1'b0;
    od  = 1'b0;
    for (int i = 0; i < NPADS; i++)
    begin
      if (gpioCfg[i].gpioSelect && i != `PAD_CAN_RX && i != `PAD_CAN_TX)
      begin
        oe  = gpioCfg[i].gpioDirOut;
        val = gpioCfg[i].gpioData;
        od  = gpioCfg[i].openDrain;
      end
      else
      begin
        oe  = periphOe[i];
        val = periphOut[i];
        od  = periphOd[i];
      end
      if (oe && od)
      begin
        // Open drain: actively drive only the low level
        next_padCtrl[i].outEnable = !val;
        next_padCtrl[i].outValue  = 1'b0;
        next_padCtrl[i].pullupOn  = val & pullEnable[i];
      end
      else
      begin
        next_padCtrl[i].outEnable = oe;
        next_padCtrl[i].outValue  = val;
        next_padCtrl[i].pullupOn  = !oe & pullEnable[i];
      end
    end
  end

  // Pad control register; reset leaves inputs with pull-ups
  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      for (int i = 0; i < NPADS; i++)
      begin
        padCtrl[i].outEnable <= 1'b0;
        padCtrl[i].outValue  <= 1'b0;
        padCtrl[i].pullupOn  <= 1'b1;
      end
    end
    else
    begin
      padCtrl <= next_padCtrl;
    end
  end

  // Peripheral inputs; a pad in GPIO mode feeds the peripheral idle high
  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      gpioIn         <= '0;
      decoder0Index  <= 1'b1;
      decoder0Home   <= 1'b1;
      decoder1PhaseA <= 1'b1;
      decoder1PhaseB <= 1'b1;
      spi0ClockIn    <= 1'b1;
      spi1ClockIn    <= 1'b1;
      spi1DataIn     <= 1'b1;
      canRxData      <= 1'b1;
      timerC0In      <= 1'b1;
      timerC1In      <= 1'b1;
    end
    else
    begin
      gpioIn <= padSync;
      decoder0Index <= gpioCfg[`PAD_DECODER0_INDEX_PIN].gpioSelect
                       | padSync[`PAD_DECODER0_INDEX_PIN];
      decoder0Home <= gpioCfg[`PAD_DECODER0_HOME_PIN].gpioSelect
                      | padSync[`PAD_DECODER0_HOME_PIN];
      spi0ClockIn <= gpioCfg[`PAD_SPI0_CLOCK].gpioSelect | spi0Master
                     | padSync[`PAD_SPI0_CLOCK];
      decoder1PhaseA <= gpioCfg[`PAD_PHASE_A1].gpioSelect
                        | phaseAAlternateSelect
                        | padSync[`PAD_PHASE_A1];
      decoder1PhaseB <= gpioCfg[`PAD_PHASE_B1].gpioSelect
                        | phaseBAlternateSelect
                        | padSync[`PAD_PHASE_B1];
      spi1ClockIn <= !phaseAAlternateSelect | spi1Master
                     | gpioCfg[`PAD_PHASE_A1].gpioSelect
                     | padSync[`PAD_PHASE_A1];
      spi1DataIn <= !phaseBAlternateSelect | spi1Master
                    | gpioCfg[`PAD_PHASE_B1].gpioSelect
                    | padSync[`PAD_PHASE_B1];
      canRxData <= padSync[`PAD_CAN_RX];
      timerC0In <= gpioCfg[`PAD_TIMERC0].gpioSelect
                   | padSync[`PAD_TIMERC0];
      timerC1In <= gpioCfg[`PAD_TIMERC1].gpioSelect
                   | padSync[`PAD_TIMERC1];
    end
  end

  // Checks
  property p_reset_pullups;
    @(posedge clk) !rstSync |=> padCtrl[`PAD_DECODER0_INDEX_PIN].pullupOn
      && !padCtrl[`PAD_DECODER0_INDEX_PIN].outEnable;
  endproperty
  a_reset_pullups: assert property (p_reset_pullups)
    else $error("pad not input with pull-up in reset");

  property p_index_pull;
    @(posedge clk) disable iff (!rstSync)
    !portCPullupEnable[`PORTC_PUR_DECODER0_INDEX_PIN_BIT] |=>
      !padCtrl[`PAD_DECODER0_INDEX_PIN].pullupOn;
  endproperty
  a_index_pull: assert property (p_index_pull)
    else $error("index pull-up not removed");

  property p_home_pull;
    @(posedge clk) disable iff (!rstSync)
    !portCPullupEnable[`PORTC_PUR_DECODER0_HOME_PIN_BIT] |=>
      !padCtrl[`PAD_DECODER0_HOME_PIN].pullupOn;
  endproperty
  a_home_pull: assert property (p_home_pull)
    else $error("home pull-up not removed");

  property p_spi0_master;
    @(posedge clk) disable iff (!rstSync)
    spi0Master && !gpioCfg[`PAD_SPI0_CLOCK].gpioSelect |=>
      padCtrl[`PAD_SPI0_CLOCK].outEnable
      && padCtrl[`PAD_SPI0_CLOCK].outValue == $past(spi0ClockOut);
  endproperty
  a_spi0_master: assert property (p_spi0_master)
    else $error("spi0 clock not driven as master");

  property p_phase_a_alt;
    @(posedge clk) disable iff (!rstSync)
    phaseAAlternateSelect && spi1Master
      && !gpioCfg[`PAD_PHASE_A1].gpioSelect |=>
      padCtrl[`PAD_PHASE_A1].outEnable;
  endproperty
  a_phase_a_alt: assert property (p_phase_a_alt)
    else $error("phase A1 pad not routed to spi1 clock");

  property p_can_pull;
    @(posedge clk) disable iff (!rstSync)
    canPullupDisable |=> !padCtrl[`PAD_CAN_RX].pullupOn;
  endproperty
  a_can_pull: assert property (p_can_pull)
    else $error("can receive pull-up not disabled");

  property p_open_drain_low;
    @(posedge clk) disable iff (!rstSync)
    !canTxData && !gpioCfg[`PAD_CAN_TX].gpioSelect |=>
      padCtrl[`PAD_CAN_TX].outEnable && !padCtrl[`PAD_CAN_TX].pullupOn;
  endproperty
  a_open_drain_low: assert property (p_open_drain_low)
    else $error("open drain low with pull-up");

  property p_push_pull;
    @(posedge clk) disable iff (!rstSync)
    padCtrl[`PAD_TIMERC0].outEnable |-> !padCtrl[`PAD_TIMERC0].pullupOn;
  endproperty
  a_push_pull: assert property (p_push_pull)
    else $error("push-pull pad with pull-up on");

  property p_gpio_override;
    @(posedge clk) disable iff (!rstSync)
    gpioCfg[`PAD_DECODER0_INDEX_PIN].gpioSelect && gpioCfg[`PAD_DECODER0_INDEX_PIN].gpioDirOut
      && !gpioCfg[`PAD_DECODER0_INDEX_PIN].openDrain |=>
      padCtrl[`PAD_DECODER0_INDEX_PIN].outEnable
      && padCtrl[`PAD_DECODER0_INDEX_PIN].outValue == $past(gpioCfg[`PAD_DECODER0_INDEX_PIN].gpioData);
  endproperty
  a_gpio_override: assert property (p_gpio_override)
    else $error("gpio did not take the pad");

  c_spi1_route: cover property (@(posedge clk) phaseAAlternateSelect
    && spi1Master ##1 padCtrl[`PAD_PHASE_A1].outEnable);
  c_can_low: cover property (@(posedge clk) padCtrl[`PAD_CAN_TX].outEnable);
  c_gpio_out: cover property (@(posedge clk)
    padCtrl[`PAD_DECODER0_HOME_PIN].outEnable);
endmodule

// ===== verif/pad_ring_model.sv
`timescale 1ns/100ps
module pad_ring_model #(
  parameter int NPADS = 9
) (
  input  wire logic                             clk,
  input  wire pin_mux_pkg::pad_ctrl_type [NPADS-1:0] padCtrl,
  input  wire logic [NPADS-1:0]                 extOn,
  input  wire logic [NPADS-1:0]                 extVal,
  output logic [NPADS-1:0]                      padIn
);
  logic floatPat = 1'h0;
  // An undriven pad without pull-up wanders instead of holding its value
  always_ff @(posedge clk)
    floatPat <= ~floatPat;
  always_comb
    for (int i = 0; i < NPADS; i++)
      if (padCtrl[i].outEnable)
        padIn[i] = padCtrl[i].outValue;
      else if (extOn[i])
        padIn[i] = extVal[i];
      else
        padIn[i] = padCtrl[i].pullupOn | floatPat;
endmodule

// ===== verif/multiplexed_pin_function_select_tb_top.sv
`timescale 1ns/100ps
module multiplexed_pin_function_select_tb_top;
  localparam int NP = 9;
  logic                               clk = 1'h0;
  logic                               rst_b = 1'h0;
  logic [15:0]                        portC, portE;
  logic                               canDis, altA, altB, canTx, spi0M, spi0Co;
  logic                               spi1M, spi1Co, spi1Do, tc0O, tc0E;
  logic                               tc1O, tc1E, spi1Ci, spi1Di;
  logic                               dec0Idx, dec0Home, dec1A, dec1B;
  logic                               spi0Ci, canRx, tc0In, tc1In;
  pin_mux_pkg::gpio_cfg_type [NP-1:0] gpioCfg;
  pin_mux_pkg::pad_ctrl_type [NP-1:0] padCtrl;
  logic [NP-1:0]                      extOn, extVal, padIn, gpioIn;
  logic [7:0]                         ins;
  int                                 nMismatch = 0;
  int                                 numChecks = 0;
  assign ins = {dec0Idx, dec0Home, spi0Ci, dec1A, dec1B, canRx, tc0In, tc1In};
  always #4 clk = ~clk;
  multiplexed_pin_function_select #(.NPADS(NP)) multiplexed_pin_function_select_i (
    .clk(clk), .rst_b(rst_b), .portCPullupEnable(portC),
    .portEPullupEnable(portE), .canPullupDisable(canDis),
    .phaseAAlternateSelect(altA), .phaseBAlternateSelect(altB),
    .gpioCfg(gpioCfg), .spi0Master(spi0M), .spi0ClockOut(spi0Co),
    .spi1Master(spi1M), .spi1ClockOut(spi1Co), .spi1DataOut(spi1Do),
    .canTxData(canTx), .timerC0Out(tc0O), .timerC0OutEnable(tc0E),
    .timerC1Out(tc1O), .timerC1OutEnable(tc1E), .padIn(padIn),
    .padCtrl(padCtrl), .gpioIn(gpioIn), .decoder0Index(dec0Idx),
    .decoder0Home(dec0Home), .decoder1PhaseA(dec1A), .decoder1PhaseB(dec1B),
    .spi0ClockIn(spi0Ci), .spi1ClockIn(spi1Ci), .spi1DataIn(spi1Di),
    .canRxData(canRx), .timerC0In(tc0In), .timerC1In(tc1In));
  pad_ring_model #(.NPADS(NP)) pad_ring_model_i (
    .clk(clk), .padCtrl(padCtrl), .extOn(extOn), .extVal(extVal),
    .padIn(padIn));
  task automatic tick(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk_val(logic [8:0] e, logic [8:0] g);
    numChecks++;
    if (g !== e)
    begin
      nMismatch++;
      $display("Error at %0t: expected %h, got %h", $time, e, g);
    end
  endtask
  // Output value only matters while the pad is driven
  task automatic chk_ctrl(int i, logic [2:0] e);
    pin_mux_pkg::pad_ctrl_type g;
    g = padCtrl[i];
    chk_val({6'h00, e},
      {6'h00, g.outEnable, g.outEnable & g.outValue, g.pullupOn});
  endtask
  function automatic logic pu_bit(int i);
    case (i)
      0: return portC[6];
      1: return portC[7];
      2: return portE[4];
      3: return portC[0];
      4: return portC[1];
      7: return portE[8];
      default: return portE[9];
    endcase
  endfunction
  function automatic logic [2:0] exp_gpio(int i);
    pin_mux_pkg::gpio_cfg_type c;
    c = gpioCfg[i];
    if (!c.gpioDirOut || (c.openDrain && c.gpioData))
      return {2'h0, pu_bit(i)};
    if (!c.openDrain)
      return {1'h1, c.gpioData, 1'h0};
    return 3'h4;
  endfunction
  task automatic idle();
    {canDis, altA, altB, spi0M, spi0Co, spi1M} = 6'h00;
    {spi1Co, spi1Do, tc0O, tc0E, tc1O, tc1E} = 6'h00;
    canTx = 1'h1;
    portC = 16'hFFFF;
    portE = 16'hFFFF;
    gpioCfg = '0;
    extOn = '0;
    extVal = '0;
  endtask
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #(8 * 20000);
    nMismatch++;
    wrap_up();
  end
  initial
  begin
    idle();
    void'($urandom(32'h9D18));
    portC = 16'h0000;
    spi0M = 1'h1;
    tick(10);
    for (int i = 0; i < NP; i++)
      chk_ctrl(i, 3'h1);
    chk_val(9'h0FF, {1'h0, ins});
    $display("Test reset state done");
    idle();
    tick(10);
    rst_b = 1'h1;
    tick(5);
    for (int v = 0; v < 2; v++)
    begin
      extOn = 9'h1BF;
      extVal = {NP{v[0]}};
      tick(4);
      for (int i = 0; i < NP; i++)
        chk_ctrl(i, 3'h1);
      chk_val({1'h0, {8{v[0]}}}, {1'h0, ins});
    end
    $display("Test default functions done");
    extOn = '0;
    for (int k = 0; k < 8; k++)
    begin
      portC = (k == 0) ? 16'h0000 : 16'($urandom);
      portE = (k == 0) ? 16'h0000 : 16'($urandom);
      canDis = (k == 0) ? 1'h1 : 1'($urandom);
      tick(2);
      for (int i = 0; i < NP; i++)
        chk_ctrl(i, {2'h0, (i == 5 || i == 6) ? !canDis : pu_bit(i)});
    end
    $display("Test pull-up control done");
    idle();
    {altA, altB, spi0M, spi1M, tc0E, tc1E} = 6'h3F;
    for (int v = 0; v < 2; v++)
    begin
      {spi0Co, spi1Co, tc0O, canTx} = {4{v[0]}};
      {spi1Do, tc1O} = {2{!v[0]}};
      tick(4);
      chk_ctrl(2, {1'h1, v[0], 1'h0});
      chk_ctrl(3, {1'h1, v[0], 1'h0});
      chk_ctrl(4, {1'h1, !v[0], 1'h0});
      chk_ctrl(7, {1'h1, v[0], 1'h0});
      chk_ctrl(8, {1'h1, !v[0], 1'h0});
      chk_ctrl(6, v[0] ? 3'h1 : 3'h4);
      chk_val(9'h01F, {4'h0, spi0Ci, spi1Ci, spi1Di, dec1A, dec1B});
    end
    spi1M = 1'h0;
    extOn = 9'h018;
    tick(4);
    chk_val(9'h000, {7'h00, spi1Ci, spi1Di});
    $display("Test peripheral outputs done");
    idle();
    for (int k = 0; k < 40; k++)
    begin
      portC = 16'($urandom);
      portE = 16'($urandom);
      {altA, altB, spi0M, spi1M, tc0E, tc1E} = 6'($urandom);
      for (int i = 0; i < NP; i++)
      begin
        gpioCfg[i] = {1'h1, 3'($urandom)};
        extOn[i] = !gpioCfg[i].gpioDirOut && i != 5 && i != 6;
        extVal[i] = 1'($urandom);
      end
      tick(4);
      for (int i = 0; i < NP; i++)
        if (i == 5 || i == 6)
          chk_ctrl(i, 3'h1);
        else
          chk_ctrl(i, exp_gpio(i));
      chk_val(extVal & extOn, gpioIn & extOn);
      chk_val(9'h1FF, {ins, spi1Ci & spi1Di});
    end
    $display("Test gpio override done");
    wrap_up();
  end
endmodule
